/* File: acs_pkg.sv */
package acs_pkg;

  // pins arriving from the host side of the board
  typedef struct packed {
    logic sclk;
    logic din;
    logic cs_n;
    logic sync;
    logic rst;
  } acs_pins_s;

  // register addresses
  localparam logic [3:0] ADDR_CONFIG0  = 4'h1;
  localparam logic [3:0] ADDR_FSC_LOW  = 4'h8;
  localparam logic [3:0] ADDR_FSC_MID  = 4'h9;
  localparam logic [3:0] ADDR_FSC_HIGH = 4'ha;

  // reset values
  localparam logic [7:0] RST_CONFIG0  = 8'h52;
  localparam logic [7:0] RST_FSC_LOW  = 8'h00;
  localparam logic [7:0] RST_FSC_MID  = 8'h00;
  localparam logic [7:0] RST_FSC_HIGH = 8'h40;

  // field positions
  localparam int SYNC_MODE_BIT = 7;
  localparam int RES_MSB       = 45;
  localparam int RES_LSB       = 22;

  // command opcodes
  localparam logic [7:0] CMD_START_CONT = 8'h10;
  localparam logic [7:0] CMD_STOP_CONT  = 8'h11;
  localparam logic [7:0] CMD_READ_RES   = 8'h12;
  localparam logic [3:0] OP_REG_READ    = 4'h2;
  localparam logic [3:0] OP_REG_WRITE   = 4'h4;

  // timing
  localparam int         CLK_MHZ         = 125;
  localparam int         CONV_PERIOD_US  = 1000;
  localparam int         CONV_CYCLES     = CONV_PERIOD_US * CLK_MHZ;
  localparam int         CONV_CNT_W      = 17;
  localparam logic [5:0] DISCARD_READS   = 6'h3f;
  localparam logic [6:0] IDLE_SCLK_PERS  = 7'h40;
  localparam logic [1:0] RESULT_BYTES_M1 = 2'h2;

  typedef enum logic [2:0] {
    IF_IDLE   = 3'b000,
    IF_RCOUNT = 3'b001,
    IF_RDATA  = 3'b010,
    IF_WCOUNT = 3'b011,
    IF_WDATA  = 3'b100,
    IF_RESULT = 3'b101
  } acs_if_e;

  typedef struct packed {
    acs_if_e               st;
    logic [2:0]            bit_cnt;
    logic [7:0]            rx;
    logic [23:0]           tx;
    logic                  fresh;
    logic [3:0]            addr;
    logic [7:0]            left;
    logic                  cont;
    logic                  dout;
    logic                  dout_oe;
    logic                  ready_n;
    logic [7:0]            cfg0;
    logic [7:0]            fsc_low;
    logic [7:0]            fsc_mid;
    logic [7:0]            fsc_high;
    logic [CONV_CNT_W-1:0] conv_cnt;
    logic [5:0]            discard;
    logic [6:0]            idle_per;
    logic [23:0]           result;
  } acs_state_s;

endpackage

/* File: acs_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module acs_pin_sync (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // raw pins
  input  wire acs_pkg::acs_pins_s i_pins,
  // synchronised level and its previous sample
  output var  acs_pkg::acs_pins_s o_pins,
  output var  acs_pkg::acs_pins_s o_pins_prev
);
  import acs_pkg::*;

  typedef struct packed {
    acs_pins_s s1;
    acs_pins_s s2;
    acs_pins_s s3;
  } acs_sync_s;

  // chip select and sync pin idle high; reset pin idles low
  localparam acs_pins_s PIN_IDLE = '{sclk: 1'b0, din: 1'b0, cs_n: 1'b1, sync: 1'b1, rst: 1'b0};

  acs_sync_s q;
  acs_sync_s d;

  // s1 feeds s2 only; edges are taken from s2 against s3
  always_comb begin
    d    = q;
    d.s1 = i_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= '{s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE};
    end else begin
      q <= d;
    end
  end

  assign o_pins      = q.s2;
  assign o_pins_prev = q.s3;

endmodule
`default_nettype wire

/* File: acs_serial_host.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - mid calibration byte at 09h, resets 00h
// - high calibration byte at 0Ah, resets 40h
// - chip select high returns interface to idle
// - reset pin pulse also recovers interface
// - 64 idle-clock ready periods reset interface in continuous readout
// - start command enters continuous readout
// - sync held high: conversions run freely
// - pulse-sync rising edge restarts conversion timing
// - continuous mode: result clocked after ready falls
// - otherwise result only via read-result command
// - single or block register access, any mode
// - register write restarts conversion, 63 readings lost
// - sync-mode bit: 0 pulse, 1 continuous
// - registers reached only by read/write commands
// - three calibration bytes form 24-bit gain
module acs_serial_host #(
  parameter int unsigned P_CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  // host pins
  input  wire acs_pkg::acs_pins_s i_pins,
  // modulator result, same clock
  input  wire logic [23:0]       i_raw_sample,
  // outputs to host
  output var  logic              o_dout,
  output var  logic              o_dout_oe,
  output var  logic              o_conversion_ready_n,
  output var  logic              o_continuous_read
);
  import acs_pkg::*;

  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(P_CONV_CYCLES - 1);
  localparam logic [CONV_CNT_W-1:0] CONV_PRE  = CONV_CNT_W'(P_CONV_CYCLES - 2);

  localparam acs_state_s ST_RST = '{
    st:       IF_IDLE,
    bit_cnt:  3'h0,
    rx:       8'h00,
    tx:       24'h000000,
    fresh:    1'b0,
    addr:     4'h0,
    left:     8'h00,
    cont:     1'b0,
    dout:     1'b0,
    dout_oe:  1'b0,
    ready_n:  1'b1,
    cfg0:     RST_CONFIG0,
    fsc_low:  RST_FSC_LOW,
    fsc_mid:  RST_FSC_MID,
    fsc_high: RST_FSC_HIGH,
    conv_cnt: '0,
    discard:  6'h00,
    idle_per: 7'h00,
    result:   24'h000000
  };

  acs_pins_s  p;
  acs_pins_s  pp;
  acs_state_s q;
  acs_state_s d;

  logic              sclk_rise;
  logic              sclk_fall;
  logic              sync_rise;
  logic              cont_sync;
  logic              publish;
  logic              byte_done;
  logic [7:0]        rx_byte;
  logic [3:0]        addr_next;
  logic signed [48:0] prod;

  acs_pin_sync u_pin_sync (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_pins      (i_pins),
    .o_pins      (p),
    .o_pins_prev (pp)
  );

  function automatic logic [7:0] reg_rd(input acs_state_s s, input logic [3:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_CONFIG0:  v = s.cfg0;
      ADDR_FSC_LOW:  v = s.fsc_low;
      ADDR_FSC_MID:  v = s.fsc_mid;
      ADDR_FSC_HIGH: v = s.fsc_high;
      default:       v = 8'h00;
    endcase
    return v;
  endfunction

  assign sclk_rise = p.sclk & ~pp.sclk;
  assign sclk_fall = ~p.sclk & pp.sclk;
  assign sync_rise = p.sync & ~pp.sync;
  assign cont_sync = q.cfg0[SYNC_MODE_BIT];
  assign rx_byte   = {q.rx[6:0], p.din};
  assign byte_done = sclk_rise && (q.bit_cnt == 3'h7);
  assign addr_next = q.addr + 4'h1;
  // unity gain at 400000h
  assign prod = $signed(i_raw_sample) * $signed({1'b0, q.fsc_high, q.fsc_mid, q.fsc_low});

  always_comb begin
    d       = q;
    publish = 1'b0;

    // conversion timing; in pulse mode a low sync holds the modulator
    if (p.sync || cont_sync) begin
      if (q.conv_cnt == CONV_LAST) begin
        d.conv_cnt = '0;
        if (q.discard != 6'h00) begin
          d.discard = q.discard - 6'h01;
        end else begin
          d.result  = prod[RES_MSB:RES_LSB];
          d.ready_n = 1'b0;
          publish  = 1'b1;
        end
      end else begin
        d.conv_cnt = q.conv_cnt + 1'b1;
      end
    end
    if (q.conv_cnt == CONV_PRE) begin
      d.ready_n = 1'b1;
    end
    // continuous sync only realigns when the edge is off the frame
    if (sync_rise && (!cont_sync || q.conv_cnt != '0)) begin
      d.conv_cnt = '0;
    end

    // idle-clock watchdog counts published readings without clocks
    if (sclk_rise || !q.cont) begin
      d.idle_per = 7'h00;
    end else if (publish) begin
      d.idle_per = q.idle_per + 7'h01;
    end

    if (p.cs_n || q.idle_per == IDLE_SCLK_PERS) begin
      d.st       = IF_IDLE;
      d.bit_cnt  = 3'h0;
      d.fresh    = 1'b0;
      d.left     = 8'h00;
      d.idle_per = 7'h00;
      d.dout_oe  = ~p.cs_n;
      // deselected means between frames, so a host selecting after ready falls still finds the reading
      if (publish && q.cont) begin
        d.tx = prod[RES_MSB:RES_LSB];
      end
    end else begin
      d.dout_oe = 1'b1;
      // load a new reading only between frames so a read is never torn
      if (publish && q.cont && q.st == IF_IDLE && q.bit_cnt == 3'h0) begin
        d.tx    = prod[RES_MSB:RES_LSB];
        d.st    = IF_RESULT;
        d.left  = {6'h00, RESULT_BYTES_M1};
        d.fresh = 1'b0;
      end
      if (sclk_fall) begin
        d.fresh = 1'b0;
        if (!q.fresh) begin
          d.tx = {q.tx[22:0], 1'b0};
        end
      end
      if (sclk_rise) begin
        d.rx      = rx_byte;
        d.bit_cnt = q.bit_cnt + 3'h1;
        // a reading published in the same cycle keeps ready low
        if (q.st == IF_RESULT && !publish) begin
          d.ready_n = 1'b1;
        end
      end
      if (byte_done) begin
        unique case (q.st)
          IF_IDLE: begin
            if (rx_byte == CMD_START_CONT) begin
              d.cont = 1'b1;
            end else if (rx_byte == CMD_STOP_CONT) begin
              d.cont = 1'b0;
            end else if (rx_byte == CMD_READ_RES && !q.cont) begin
              d.tx     = q.result;
              d.fresh  = 1'b1;
              d.st     = IF_RESULT;
              d.left    = {6'h00, RESULT_BYTES_M1};
              d.ready_n = !publish;
            end else if (rx_byte[7:4] == OP_REG_READ) begin
              d.addr = rx_byte[3:0];
              d.st   = IF_RCOUNT;
            end else if (rx_byte[7:4] == OP_REG_WRITE) begin
              d.addr = rx_byte[3:0];
              d.st   = IF_WCOUNT;
            end
          end
          IF_RCOUNT: begin
            d.left  = rx_byte;
            d.tx    = {reg_rd(q, q.addr), 16'h0000};
            d.fresh = 1'b1;
            d.st    = IF_RDATA;
          end
          IF_RDATA: begin
            if (q.left == 8'h00) begin
              d.st = IF_IDLE;
            end else begin
              d.left  = q.left - 8'h01;
              d.addr  = addr_next;
              d.tx    = {reg_rd(q, addr_next), 16'h0000};
              d.fresh = 1'b1;
            end
          end
          IF_WCOUNT: begin
            d.left = rx_byte;
            d.st   = IF_WDATA;
          end
          IF_WDATA: begin
            case (q.addr)
              ADDR_CONFIG0:  d.cfg0     = rx_byte;
              ADDR_FSC_LOW:  d.fsc_low  = rx_byte;
              ADDR_FSC_MID:  d.fsc_mid  = rx_byte;
              ADDR_FSC_HIGH: d.fsc_high = rx_byte;
              default:       d.fsc_low  = q.fsc_low;
            endcase
            // filter restarts; stale readings are swallowed
            d.conv_cnt = '0;
            d.discard  = DISCARD_READS;
            d.ready_n  = 1'b1;
            if (q.left == 8'h00) begin
              d.st = IF_IDLE;
            end else begin
              d.left = q.left - 8'h01;
              d.addr = addr_next;
            end
          end
          IF_RESULT: begin
            if (q.cont && rx_byte == CMD_STOP_CONT) begin
              d.cont = 1'b0;
            end
            if (q.left == 8'h00) begin
              d.st = IF_IDLE;
            end else begin
              d.left = q.left - 8'h01;
            end
          end
        endcase
      end
    end

    d.dout = d.tx[23];

    // reset pin returns the whole device, interface included, to reset
    if (p.rst) begin
      d = ST_RST;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  assign o_dout               = q.dout;
  assign o_dout_oe            = q.dout_oe;
  assign o_conversion_ready_n = q.ready_n;
  assign o_continuous_read    = q.cont;

endmodule
`default_nettype wire

/* File: acs_serial_host_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_serial_host_assertions #(
  parameter int unsigned P_CONV_CYCLES = 200
) (
  // watched clock and reset
  input wire logic               i_clk,
  input wire logic               i_reset,
  // watched pins and outputs
  input wire acs_pkg::acs_pins_s i_pins,
  input wire logic [23:0]        i_raw_sample,
  input wire logic               o_dout,
  input wire logic               o_dout_oe,
  input wire logic               o_conversion_ready_n,
  input wire logic               o_continuous_read
);
  import acs_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // six cycles covers the two-flop sync plus the output register
  sequence s_cs_hi; i_pins.cs_n [*6]; endsequence
  sequence s_cs_lo; (!i_pins.cs_n && !i_pins.rst) [*6]; endsequence
  sequence s_rst_hi; i_pins.rst [*6]; endsequence
  sequence s_sync_lo; !i_pins.sync [*8]; endsequence
  property p_oe_off; s_cs_hi |-> !o_dout_oe; endproperty
  property p_oe_on; s_cs_lo |-> o_dout_oe; endproperty
  property p_rst_pin;
    s_rst_hi |-> o_conversion_ready_n && !o_continuous_read && !o_dout_oe;
  endproperty
  property p_cont_on; $rose(o_continuous_read) |-> !i_pins.cs_n; endproperty
  property p_cont_off; $fell(o_continuous_read) |-> !i_pins.cs_n || i_pins.rst; endproperty
  property p_oe_rise; $rose(o_dout_oe) |-> !i_pins.cs_n; endproperty
  property p_rdy_low; $fell(o_conversion_ready_n) |-> !o_conversion_ready_n [*2]; endproperty
  property p_sync_halt; s_sync_lo |-> !$fell(o_conversion_ready_n); endproperty
  a_oe_off: assert property (p_oe_off) else $error("dout enabled while deselected");
  a_oe_on: assert property (p_oe_on) else $error("dout not enabled while selected");
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin did not idle outputs");
  a_cont_on: assert property (p_cont_on) else $error("continuous mode set unselected");
  a_cont_off: assert property (p_cont_off) else $error("continuous mode dropped unasked");
  a_oe_rise: assert property (p_oe_rise) else $error("drive began without select");
  a_rdy_low: assert property (p_rdy_low) else $error("ready pulse too short");
  a_sync_halt: assert property (p_sync_halt) else $error("reading while sync low");
endmodule
bind acs_serial_host acs_serial_host_assertions #(.P_CONV_CYCLES(P_CONV_CYCLES)) u_chk (
  .i_clk                (i_clk),
  .i_reset              (i_reset),
  .i_pins               (i_pins),
  .i_raw_sample         (i_raw_sample),
  .o_dout               (o_dout),
  .o_dout_oe            (o_dout_oe),
  .o_conversion_ready_n (o_conversion_ready_n),
  .o_continuous_read    (o_continuous_read)
);
`default_nettype wire

/* File: acs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  // clock
  input  wire logic i_clk,
  // serial lines
  input  wire logic i_dout,
  output var  logic o_sclk,
  output var  logic o_din,
  output var  logic o_cs_n
);
  initial begin
    o_sclk = 1'b0;
    o_din = 1'b0;
    o_cs_n = 1'b1;
  end
  task automatic sel(input logic v);
    @(negedge i_clk);
    o_cs_n = v;
    // released line must not keep looking valid
    if (v) o_din = ~o_din;
    repeat (4) @(negedge i_clk);
  endtask
  // 80 ns serial period, dout taken just before each rise
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      o_din = tx[i];
      rx[i] = i_dout;
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      o_sclk = 1'b0;
      repeat (5) @(negedge i_clk);
    end
  endtask
endmodule
`default_nettype wire

/* File: acs_serial_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module acs_serial_host_tb;
  import acs_pkg::*;
  localparam int P = 500;
  logic        clk, i_reset, sync, rst, sclk, din, cs_n, dout, oe, rdy_n, cont;
  logic [23:0] raw;
  logic [7:0]  b, r0, r1, r2, d0, d1;
  int          err_total, n_tests, seed, t;
  acs_pins_s   pins;
  assign pins = {sclk, din, cs_n, sync, rst};
  acs_serial_host #(.P_CONV_CYCLES(P)) i_dut (
    .i_clk(clk), .i_reset(i_reset), .i_pins(pins), .i_raw_sample(raw), .o_dout(dout),
    .o_dout_oe(oe), .o_conversion_ready_n(rdy_n), .o_continuous_read(cont)
  );
  acs_host_model i_host (.i_clk(clk), .i_dout(dout), .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [23:0] exp_res(logic [23:0] r, logic [23:0] g);
    logic signed [48:0] p;
    p = $signed(r) * $signed({1'b0, g});
    return p[45:22];
  endfunction
  task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmd(logic [7:0] c);
    i_host.sel(1'b0);
    i_host.xfer(c, 8, b);
    i_host.sel(1'b1);
  endtask
  // two-register block access starting at a
  task automatic reg2(logic [3:0] op, logic [3:0] a);
    i_host.sel(1'b0);
    i_host.xfer({op, a}, 8, b);
    i_host.xfer(8'h01, 8, b);
    i_host.xfer(d0, 8, r0);
    i_host.xfer(d1, 8, r1);
    i_host.sel(1'b1);
  endtask
  // skips a reading already pending, then waits for a fresh one
  task automatic wait_rdy;
    t = 0;
    while (rdy_n === 1'b0 && t < 40000) begin
      @(negedge clk);
      t++;
    end
    t = 0;
    while (rdy_n !== 1'b0 && t < 40000) begin
      @(negedge clk);
      t++;
    end
  endtask
  task automatic res_read(logic [7:0] c, logic [23:0] e);
    i_host.sel(1'b0);
    if (c != 8'h00) i_host.xfer(c, 8, b);
    i_host.xfer(8'h00, 8, r0);
    i_host.xfer(8'h00, 8, r1);
    i_host.xfer(8'h00, 8, r2);
    i_host.sel(1'b1);
    chk("result", {r0, r1, r2}, e);
  endtask
  initial begin
    i_reset = 1'b1;
    sync = 1'b1;
    rst = 1'b0;
    err_total = 0;
    n_tests = 0;
    seed = 47153;
    raw = $random(seed);
    d0 = $random(seed);
    d1 = $random(seed);
    repeat (20) @(negedge clk);
    i_reset = 1'b0;
    repeat (4) @(negedge clk);
    i_host.sel(1'b0);
    i_host.xfer(8'hff, 3, b);
    i_host.sel(1'b1);
    reg2(OP_REG_READ, ADDR_FSC_MID);
    chk("fsc_mid", 24'(r0), 24'h0);
    chk("fsc_high", 24'(r1), 24'h40);
    reg2(OP_REG_READ, 4'hb);
    chk("unmapped", 24'({r0, r1}), 24'h0);
    reg2(OP_REG_READ, ADDR_CONFIG0);
    chk("cfg0", 24'(r0), 24'(RST_CONFIG0));
    chk("sync_mode", 24'(r0[SYNC_MODE_BIT]), 24'h0);
    chk("cfg_gap", 24'(r1), 24'h0);
    wait_rdy;
    res_read(CMD_READ_RES, exp_res(raw, 24'h400000));
    chk("cont_idle", 24'(cont), 24'h0);
    sync = 1'b0;
    repeat (50) @(negedge clk);
    sync = 1'b1;
    wait_rdy;
    chk("resync", 24'(t inside {[P - 4:P + 12]}), 24'h1);
    cmd(CMD_START_CONT);
    chk("cont_on", 24'(cont), 24'h1);
    wait_rdy;
    res_read(8'h00, exp_res(raw, 24'h400000));
    // stray clocks, then 64 readings with no clock while selected
    i_host.sel(1'b0);
    i_host.xfer(8'hff, 3, b);
    repeat (64 * P + 10) @(negedge clk);
    wait_rdy;
    res_read(8'h00, exp_res(raw, 24'h400000));
    chk("cont_kept", 24'(cont), 24'h1);
    cmd(CMD_STOP_CONT);
    chk("cont_off", 24'(cont), 24'h0);
    reg2(OP_REG_WRITE, ADDR_FSC_MID);
    reg2(OP_REG_READ, ADDR_FSC_MID);
    chk("wr_mid", 24'(r0), 24'(d0));
    chk("wr_high", 24'(r1), 24'(d1));
    wait_rdy;
    chk("discard", 24'(t >= 63 * P), 24'h1);
    res_read(CMD_READ_RES, exp_res(raw, {d1, d0, 8'h00}));
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    reg2(OP_REG_READ, ADDR_FSC_MID);
    chk("rst_mid", 24'(r0), 24'h0);
    chk("rst_high", 24'(r1), 24'h40);
    wrap_up;
  end
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    wrap_up;
  end
endmodule
`default_nettype wire
